// [tcp_regs.svh]
// Purpose: register offsets, field positions, reset values and counts of the timer capture/pwm
// Assumes: byte-wide register port, 8-bit addresses
// Notes: definitions only
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH
`define TCP_OFF_CAP_LO 8'h26
`define TCP_OFF_CAP_HI 8'h27
`define TCP_OFF_CMPB_LO 8'h28
`define TCP_OFF_CMPB_HI 8'h29
`define TCP_OFF_CMPA_LO 8'h2A
`define TCP_OFF_CMPA_HI 8'h2B
`define TCP_OFF_CNT_LO 8'h2C
`define TCP_OFF_CNT_HI 8'h2D
`define TCP_OFF_CTL_B 8'h2E
`define TCP_OFF_CTL_A 8'h2F
`define TCP_OFF_FLAGS 8'h38
`define TCP_OFF_IEN 8'h39
`define TCP_CTLA_MODE_A 7
`define TCP_CTLA_MODE_B 5
`define TCP_CTLA_PWM_SEL 1
`define TCP_CTLB_NOISE 7
`define TCP_CTLB_EDGE 6
`define TCP_CTLB_CTC 3
`define TCP_CTLB_MASK 8'hC8
`define TCP_FLG_OVF 0
`define TCP_FLG_CMPA 1
`define TCP_FLG_CMPB 2
`define TCP_FLG_CAP 3
`define TCP_RST_BYTE 8'h00
`define TCP_RST_WORD 16'h0000
`define TCP_RST_FLAGS 4'h0
`define TCP_TOP_8 16'h00FF
`define TCP_TOP_9 16'h01FF
`define TCP_TOP_10 16'h03FF
`define TCP_TOP_FULL 16'hFFFF
`define TCP_FILT_LEN 4
`endif

// [tcp_pkg.sv]
// Purpose: types shared by the timer capture/pwm modules
// Assumes: nothing beyond the register header
// Notes: every module state is one packed struct
package tcp_pkg;
   typedef enum logic [1:0] {TCP_MODE_NORMAL, TCP_MODE_PHASE, TCP_MODE_WRAP} tcp_mode_e;

   typedef struct packed {
      logic lvl;
   } tcp_chan_s;

   typedef struct packed {
      logic [3:0] smp;
      logic lvl;
   } tcp_cap_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic up;
      logic blk;
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic [7:0] tmp;
      logic [15:0] buf_a;
      logic [15:0] act_a;
      logic [15:0] buf_b;
      logic [15:0] act_b;
      logic [15:0] cap;
      logic [3:0] flags;
      logic [3:0] ien;
      logic [7:0] rdata;
   } tcp_top_s;
endpackage

// [tcp_cnt_if.sv]
// Purpose: counter view shared from the timer core to its two channel units
// Assumes: single clock domain
// Notes: no clocking block
`timescale 1ns/100ps
`default_nettype none
interface tcp_cnt_if;
   logic [15:0] cnt;
   logic pwm_on;
   logic ctc;
   logic going_up;
   logic wrap;
   modport src (output cnt, output pwm_on, output ctc, output going_up, output wrap);
   modport dst (input cnt, input pwm_on, input ctc, input going_up, input wrap);
endinterface // tcp_cnt_if
`default_nettype wire

// [tcp_capture.sv]
// Purpose: capture pin edge detection with optional four-sample filter
// Assumes: pin synchronous to clk; ce is the timer tick
// Notes: evt is a one-tick pulse, combinational
`timescale 1ns/100ps
`default_nettype none
module tcp_capture (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic pin,
   input wire logic edge_sel,
   input wire logic filt_en,
   output logic evt
);
   import tcp_pkg::*;
   tcp_cap_s q, d;
   logic all_hi, all_lo;

   always_comb begin
      d = q;
      all_hi = &q.smp;
      all_lo = ~|q.smp;
      evt = 1'b0;
      if (ce) begin
         d.smp = {q.smp[2:0], pin};
         if (!filt_en)
            d.lvl = pin;
         else if (all_hi)
            d.lvl = 1'b1;
         else if (all_lo)
            d.lvl = 1'b0;
         evt = (d.lvl == edge_sel) && (q.lvl != edge_sel);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // tcp_capture
`default_nettype wire

// [tcp_pwm_chan.sv]
// Purpose: one compare channel: match detect and pwm pin level
// Assumes: cmp already masked to the resolution
// Notes: overflow beats match in wrap mode so a value of top holds the pin steady
`timescale 1ns/100ps
`default_nettype none
module tcp_pwm_chan (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   tcp_cnt_if.dst cif,
   input wire logic [1:0] mode,
   input wire logic [15:0] cmp,
   output logic hit,
   output logic pin_out,
   output logic pin_oe
);
   import tcp_pkg::*;
   tcp_chan_s q, d;

   always_comb begin
      d = q;
      hit = ce && (cif.cnt == cmp);
      if (ce && cif.pwm_on && mode[1]) begin
         if (cif.ctc) begin
            if (cif.wrap)
               d.lvl = ~mode[0];
            else if (hit)
               d.lvl = mode[0];
         end else if (hit) begin
            d.lvl = cif.going_up ? mode[0] : ~mode[0];
         end
      end
   end

   assign pin_out = q.lvl;
   assign pin_oe = cif.pwm_on && mode[1];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // tcp_pwm_chan
`default_nettype wire

// [tcp_top.sv]
// Purpose: 16-bit timer core with input capture and dual pwm, byte register port
// Assumes: ce is the prescaled timer tick and freezes everything, register port included
// Notes: read data stands the cycle after the read strobe
// How it works
// - on the chosen capture edge the counter is copied and capture flag set together
// - capture value is 16 bits, read only, zero after reset
// - capture low read returns low byte and parks high byte in shared temp
// - phase-correct mode counts zero up to top and back down, forever
// - resolution selects top 255, 511 or 1023
// - clear-on-match select in pwm wraps top to zero, period top plus one
// - match when counter equals masked compare value; pin follows its mode field
// - phase-correct modes: 00 off, 01 reserved, 10 clear up set down, 11 reverse
// - wrap modes: 00 off, 01 reserved, 10 clear match set overflow, 11 reverse
// - in pwm, counter and compare bits above resolution are forced to zero
// - in pwm, compare writes go to a buffer loaded into use at top
// - compare reads return the buffered, last written value
// - phase-correct compare of zero or top gives a steady level per mode
// - wrap mode holds a steady level only for compare equal to top
// - overflow flag: leaving zero in phase-correct, wrap like normal counting
// - each request is its flag and its enable and the global enable
// - edge select zero picks falling, one picks rising capture edge
// - noise filter needs four equal samples of the selected level
// - pwm select 00 off, 01 8-bit, 10 9-bit, 11 10-bit
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "tcp_regs.svh"
module tcp_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic capture_input_pin,
   input wire logic global_int_en,
   input wire logic [3:0] irq_ack,
   output logic [3:0] irq,
   output logic pwm_out_a,
   output logic pwm_out_a_oe,
   output logic pwm_out_b,
   output logic pwm_out_b_oe,
   output tcp_pkg::tcp_mode_e timer_mode
);
   import tcp_pkg::*;

   tcp_top_s q, d;
   tcp_cnt_if cif ();
   logic [1:0] pwm_sel;
   logic [1:0] out_mode_a, out_mode_b;
   logic clear_on_match_sel;
   logic [15:0] top, cmp_a, cmp_b, wr16;
   logic hit_a, hit_b, cap_evt, ovf_evt, at_top;
   tcp_mode_e mode;

   // resolution mask, also the top value
   function automatic logic [15:0] res_mask(input logic [1:0] sel);
      case (sel)
         2'h1: res_mask = `TCP_TOP_8;
         2'h2: res_mask = `TCP_TOP_9;
         2'h3: res_mask = `TCP_TOP_10;
         default: res_mask = `TCP_TOP_FULL;
      endcase
   endfunction

   assign pwm_sel = q.ctl_a[`TCP_CTLA_PWM_SEL -: 2];
   assign out_mode_a = q.ctl_a[`TCP_CTLA_MODE_A -: 2];
   assign out_mode_b = q.ctl_a[`TCP_CTLA_MODE_B -: 2];
   assign clear_on_match_sel = q.ctl_b[`TCP_CTLB_CTC];
   assign top = res_mask(pwm_sel);
   assign at_top = (q.cnt == top);

   always_comb begin
      if (pwm_sel == 2'h0)
         mode = TCP_MODE_NORMAL;
      else if (clear_on_match_sel)
         mode = TCP_MODE_WRAP;
      else
         mode = TCP_MODE_PHASE;
   end

   assign timer_mode = mode;
   assign cmp_a = q.act_a & top;
   assign cmp_b = q.act_b & top;

   assign cif.cnt = q.cnt;
   assign cif.pwm_on = (mode != TCP_MODE_NORMAL);
   assign cif.ctc = clear_on_match_sel;
   // turning points count as the direction the counter leaves in
   assign cif.going_up = (q.cnt == 16'h0000) ? 1'b1 : (at_top ? 1'b0 : q.up);
   assign cif.wrap = (mode == TCP_MODE_WRAP) && at_top;

   tcp_pwm_chan u_chan_a (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .cif(cif),
      .mode(out_mode_a),
      .cmp(cmp_a),
      .hit(hit_a),
      .pin_out(pwm_out_a),
      .pin_oe(pwm_out_a_oe)
   );

   tcp_pwm_chan u_chan_b (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .cif(cif),
      .mode(out_mode_b),
      .cmp(cmp_b),
      .hit(hit_b),
      .pin_out(pwm_out_b),
      .pin_oe(pwm_out_b_oe)
   );

   tcp_capture u_capture (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .pin(capture_input_pin),
      .edge_sel(q.ctl_b[`TCP_CTLB_EDGE]),
      .filt_en(q.ctl_b[`TCP_CTLB_NOISE]),
      .evt(cap_evt)
   );

   always_comb begin
      case (mode)
         TCP_MODE_PHASE: ovf_evt = ce && (q.cnt == 16'h0000);
         TCP_MODE_WRAP: ovf_evt = ce && at_top;
         default: ovf_evt = ce && (q.cnt == `TCP_TOP_FULL);
      endcase
   end

   assign wr16 = {q.tmp, wdata} & top;

   always_comb begin
      d = q;
      if (ce) begin
         d.blk = 1'b0;
         // counter stepping
         case (mode)
            TCP_MODE_PHASE: begin
               if (q.up) begin
                  if (q.cnt >= top) begin
                     d.up = 1'b0;
                     d.cnt = q.cnt - 16'h0001;
                  end else begin
                     d.cnt = q.cnt + 16'h0001;
                  end
               end else begin
                  if (q.cnt == 16'h0000) begin
                     d.up = 1'b1;
                     d.cnt = 16'h0001;
                  end else begin
                     d.cnt = q.cnt - 16'h0001;
                  end
               end
            end
            TCP_MODE_WRAP: begin
               d.up = 1'b1;
               d.cnt = (q.cnt >= top) ? 16'h0000 : q.cnt + 16'h0001;
            end
            default: begin
               d.up = 1'b1;
               if (clear_on_match_sel && (q.cnt == q.act_a))
                  d.cnt = 16'h0000;
               else
                  d.cnt = q.cnt + 16'h0001;
            end
         endcase
         // double-buffered compare load at top
         if (cif.pwm_on && at_top) begin
            d.act_a = q.buf_a & top;
            d.act_b = q.buf_b & top;
         end
         // capture snapshot and its flag in the same edge
         if (cap_evt)
            d.cap = q.cnt;
         // flag clear first so a same-cycle event wins
         if (wr && addr == `TCP_OFF_FLAGS)
            d.flags = q.flags & ~wdata[3:0];
         d.flags = d.flags & ~irq_ack;
         if (ovf_evt)
            d.flags[`TCP_FLG_OVF] = 1'b1;
         if (hit_a && !q.blk)
            d.flags[`TCP_FLG_CMPA] = 1'b1;
         if (hit_b && !q.blk)
            d.flags[`TCP_FLG_CMPB] = 1'b1;
         if (cap_evt)
            d.flags[`TCP_FLG_CAP] = 1'b1;
         // register writes
         if (wr) begin
            case (addr)
               `TCP_OFF_CTL_A: d.ctl_a = wdata;
               `TCP_OFF_CTL_B: d.ctl_b = wdata & `TCP_CTLB_MASK;
               `TCP_OFF_IEN: d.ien = wdata[3:0];
               `TCP_OFF_CNT_HI, `TCP_OFF_CMPA_HI, `TCP_OFF_CMPB_HI: d.tmp = wdata;
               `TCP_OFF_CNT_LO: begin
                  d.cnt = wr16;
                  d.blk = 1'b1;
               end
               `TCP_OFF_CMPA_LO: begin
                  d.buf_a = wr16;
                  if (!cif.pwm_on)
                     d.act_a = wr16;
               end
               `TCP_OFF_CMPB_LO: begin
                  d.buf_b = wr16;
                  if (!cif.pwm_on)
                     d.act_b = wr16;
               end
               default: d.tmp = q.tmp;
            endcase
         end
         // in pwm the unused upper bits never show
         if (res_mask(d.ctl_a[`TCP_CTLA_PWM_SEL -: 2]) != `TCP_TOP_FULL) begin
            d.cnt = d.cnt & res_mask(d.ctl_a[`TCP_CTLA_PWM_SEL -: 2]);
            d.buf_a = d.buf_a & res_mask(d.ctl_a[`TCP_CTLA_PWM_SEL -: 2]);
            d.buf_b = d.buf_b & res_mask(d.ctl_a[`TCP_CTLA_PWM_SEL -: 2]);
         end
         // register reads, answered next cycle
         if (rd) begin
            case (addr)
               `TCP_OFF_CAP_LO: begin
                  d.rdata = q.cap[7:0];
                  d.tmp = q.cap[15:8];
               end
               `TCP_OFF_CAP_HI: d.rdata = q.tmp;
               `TCP_OFF_CNT_LO: begin
                  d.rdata = q.cnt[7:0];
                  d.tmp = q.cnt[15:8];
               end
               `TCP_OFF_CNT_HI: d.rdata = q.tmp;
               `TCP_OFF_CMPA_LO: d.rdata = q.buf_a[7:0];
               `TCP_OFF_CMPA_HI: d.rdata = q.buf_a[15:8];
               `TCP_OFF_CMPB_LO: d.rdata = q.buf_b[7:0];
               `TCP_OFF_CMPB_HI: d.rdata = q.buf_b[15:8];
               `TCP_OFF_CTL_A: d.rdata = q.ctl_a;
               `TCP_OFF_CTL_B: d.rdata = q.ctl_b;
               `TCP_OFF_FLAGS: d.rdata = {4'h0, q.flags};
               `TCP_OFF_IEN: d.rdata = {4'h0, q.ien};
               default: d.rdata = `TCP_RST_BYTE;
            endcase
         end
      end
   end

   assign rdata = q.rdata;
   // the temp byte carries no arbitration; software keeps it safe
   assign irq = q.flags & q.ien & {4{global_int_en}};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q.cnt <= `TCP_RST_WORD;
         q.up <= 1'b1;
         q.blk <= 1'b0;
         q.ctl_a <= `TCP_RST_BYTE;
         q.ctl_b <= `TCP_RST_BYTE;
         q.tmp <= `TCP_RST_BYTE;
         q.buf_a <= `TCP_RST_WORD;
         q.act_a <= `TCP_RST_WORD;
         q.buf_b <= `TCP_RST_WORD;
         q.act_b <= `TCP_RST_WORD;
         q.cap <= `TCP_RST_WORD;
         q.flags <= `TCP_RST_FLAGS;
         q.ien <= `TCP_RST_FLAGS;
         q.rdata <= `TCP_RST_BYTE;
      end else begin
         q <= d;
      end
   end
endmodule // tcp_top
`default_nettype wire

// [tcp_cap_src.sv]
// Purpose: capture pin source standing in for the outside world
// Assumes: pin changes just after a clock edge
// Notes: len 0 leaves the pin at lvl, otherwise it flips back after len cycles
`timescale 1ns/100ps
`default_nettype none
module tcp_cap_src (
   input wire logic clk,
   input wire logic go,
   input wire logic lvl,
   input wire logic [7:0] len,
   output logic pin
);
   logic [7:0] left_q;
   initial begin
      pin = 1'b0;
      left_q = 8'h00;
   end
   always @(posedge clk) begin
      if (go) begin
         pin <= lvl;
         left_q <= len;
      end else if (left_q > 8'h01) begin
         left_q <= left_q - 8'h01;
      end else if (left_q == 8'h01) begin
         left_q <= 8'h00;
         pin <= !pin;
      end
   end
endmodule // tcp_cap_src
`default_nettype wire

// [tcp_properties.sv]
// Purpose: port level checks of the timer capture/pwm top
// Assumes: single clock, async active low reset
// Notes: internal counter is not visible, so checks lean on register writes
`timescale 1ns/100ps
`default_nettype none
`include "tcp_regs.svh"
module tcp_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic capture_input_pin,
   input wire logic global_int_en,
   input wire logic [3:0] irq_ack,
   input wire logic [3:0] irq,
   input wire logic pwm_out_a,
   input wire logic pwm_out_a_oe,
   input wire logic pwm_out_b,
   input wire logic pwm_out_b_oe,
   input wire tcp_pkg::tcp_mode_e timer_mode
);
   import tcp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic ctla_wr;
   assign ctla_wr = wr && ce && addr == `TCP_OFF_CTL_A;
   a_irq_gated: assert property (
      !global_int_en |-> irq == 4'h0) else $error("irq without global enable");
   a_mode_off: assert property (
      ctla_wr && wdata[1:0] == 2'b00 |=> timer_mode == TCP_MODE_NORMAL)
      else $error("pwm select 00 left pwm on");
   a_mode_on: assert property (
      ctla_wr && wdata[1:0] != 2'b00 |=> timer_mode != TCP_MODE_NORMAL)
      else $error("pwm select did not start pwm");
   a_oe_a: assert property (
      ctla_wr |=> pwm_out_a_oe == ($past(wdata[7]) && $past(wdata[1:0]) != 2'b00))
      else $error("pin a drive wrong");
   a_oe_b: assert property (
      ctla_wr |=> pwm_out_b_oe == ($past(wdata[5]) && $past(wdata[1:0]) != 2'b00))
      else $error("pin b drive wrong");
   a_oe_normal: assert property (
      timer_mode == TCP_MODE_NORMAL |-> !pwm_out_a_oe && !pwm_out_b_oe)
      else $error("pin driven outside pwm");
   a_tick_freeze: assert property (
      !ce |=> $stable(rdata) && $stable(pwm_out_a) && $stable(pwm_out_b))
      else $error("state moved without tick");
   a_ack_clear: assert property (
      ($stable(capture_input_pin) [*8] ##0 (irq_ack[3] && ce)) |=> !irq[3])
      else $error("capture request survived service");
   c_pwm_a: cover property ($rose(pwm_out_a));
   c_irq_cap: cover property (irq[3]);
   c_wrap: cover property (timer_mode == TCP_MODE_WRAP);
endmodule // tcp_properties
bind tcp_top tcp_properties tcp_properties_i (.clk(clk), .resetn(resetn), .ce(ce),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .capture_input_pin(capture_input_pin), .global_int_en(global_int_en),
   .irq_ack(irq_ack), .irq(irq), .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe),
   .pwm_out_b(pwm_out_b), .pwm_out_b_oe(pwm_out_b_oe), .timer_mode(timer_mode));
`default_nettype wire

// [tcp_top_tb_top.sv]
// Purpose: register level tests of the timer capture/pwm top
// Assumes: ce held high except one short freeze
// Notes: 16-bit writes go high byte first, reads low byte first
`timescale 1ns/100ps
`default_nettype none
module tcp_top_tb_top;
   import tcp_pkg::*;
   logic clk, resetn, ce, wr, rd, gie, go, lvl, msel, pin;
   logic [7:0] addr, wdata, rdata, len;
   logic [3:0] irq_ack, irq;
   logic pa, pa_oe, pb, pb_oe;
   logic [15:0] h, l;
   tcp_mode_e tmode;
   int n_fail, n_tests;
   wire logic mp = msel ? pb : pa;
   tcp_top tcp_top_i (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .capture_input_pin(pin), .global_int_en(gie),
      .irq_ack(irq_ack), .irq(irq), .pwm_out_a(pa), .pwm_out_a_oe(pa_oe), .pwm_out_b(pb),
      .pwm_out_b_oe(pb_oe), .timer_mode(tmode));
   tcp_cap_src tcp_cap_src_i (.clk(clk), .go(go), .lvl(lvl), .len(len), .pin(pin));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(16'(rdata & m), 16'(e));
   endtask
   task automatic pinset(input logic lv, input logic [7:0] n);
      @(posedge clk);
      go <= 1'b1;
      lvl <= lv;
      len <= n;
      @(posedge clk);
      go <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // waits for a rise, then counts high and low cycles of one period
   task automatic meas(input logic s, output logic [15:0] hi, output logic [15:0] lo);
      msel = s;
      hi = 16'h0000;
      lo = 16'h0000;
      @(posedge mp);
      do begin @(posedge clk); #1 hi++; end while (mp === 1'b1);
      do begin @(posedge clk); #1 lo++; end while (mp === 1'b0);
   endtask
   // settle past one latch and one match before counting
   task automatic hsum(output logic [15:0] hi);
      hi = 16'h0000;
      repeat (1040) @(posedge clk);
      repeat (512) begin @(posedge clk); #1 if (pa === 1'b1) hi++; end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      gie = 1'b0;
      irq_ack = 4'h0;
      go = 1'b0;
      lvl = 1'b0;
      len = 8'h00;
      msel = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rc(8'h26, 8'hFF, 8'h00);
      wreg(8'h26, 8'hFF);
      rc(8'h26, 8'hFF, 8'h00);
      rc(8'h27, 8'hFF, 8'h00);
      rc(8'h00, 8'hFF, 8'h00);
      chk(16'({pa_oe, pb_oe, 2'(tmode)}), 16'(TCP_MODE_NORMAL));
      wreg(8'h2D, 8'h12);
      wreg(8'h2C, 8'h00);
      wreg(8'h2E, 8'h40);
      pinset(1'b1, 8'h00);
      rc(8'h38, 8'h08, 8'h08);
      rc(8'h26, 8'hFF, 8'h04);
      rc(8'h27, 8'hFF, 8'h12);
      wreg(8'h38, 8'h08);
      rc(8'h38, 8'h08, 8'h00);
      pinset(1'b0, 8'h00);
      rc(8'h38, 8'h08, 8'h00);
      wreg(8'h2E, 8'h00);
      pinset(1'b1, 8'h00);
      rc(8'h38, 8'h08, 8'h00);
      pinset(1'b0, 8'h00);
      rc(8'h38, 8'h08, 8'h08);
      wreg(8'h38, 8'h08);
      wreg(8'h2E, 8'hC0);
      pinset(1'b1, 8'h03);
      rc(8'h38, 8'h08, 8'h00);
      pinset(1'b1, 8'h00);
      rc(8'h38, 8'h08, 8'h08);
      // no temp byte access while interrupts are on
      wreg(8'h39, 8'h08);
      gie <= 1'b1;
      @(posedge clk);
      #1 chk(16'(irq), 16'h0008);
      @(posedge clk);
      irq_ack <= 4'h8;
      @(posedge clk);
      irq_ack <= 4'h0;
      #1 chk(16'(irq), 16'h0000);
      @(posedge clk);
      gie <= 1'b0;
      ce <= 1'b0;
      wreg(8'h39, 8'h0F);
      ce <= 1'b1;
      rc(8'h39, 8'hFF, 8'h08);
      wreg(8'h2F, 8'hB1);
      #1 chk(16'({pa_oe, pb_oe, 2'(tmode)}), 16'({2'b11, 2'(TCP_MODE_PHASE)}));
      wreg(8'h2B, 8'h12);
      wreg(8'h2A, 8'h40);
      wreg(8'h29, 8'h00);
      wreg(8'h28, 8'h40);
      rc(8'h2A, 8'hFF, 8'h40);
      rc(8'h2B, 8'hFF, 8'h00);
      meas(1'b0, h, l);
      meas(1'b0, h, l);
      chk(h, 16'h0080);
      chk(h + l, 16'h01FE);
      meas(1'b1, h, l);
      chk(h, 16'h017E);
      wreg(8'h38, 8'h01);
      repeat (520) @(posedge clk);
      rc(8'h38, 8'h01, 8'h01);
      wreg(8'h2E, 8'h08);
      for (int s = 1; s < 4; s++) begin
         wreg(8'h2F, 8'h80 | 8'(s));
         #1 chk(16'({pa_oe, pb_oe, 2'(tmode)}), 16'({2'b10, 2'(TCP_MODE_WRAP)}));
         meas(1'b0, h, l);
         meas(1'b0, h, l);
         chk(h + l, 16'h0100 << (s - 1));
         chk(h, 16'h0041);
      end
      wreg(8'h2F, 8'h81);
      wreg(8'h2B, 8'h00);
      wreg(8'h2A, 8'hFF);
      hsum(h);
      chk(h, 16'h0200);
      wreg(8'h2A, 8'h00);
      hsum(h);
      chk(h, 16'h0002);
      wreg(8'h2E, 8'h00);
      hsum(h);
      chk(h, 16'h0000);
      wreg(8'h2A, 8'hFF);
      hsum(h);
      chk(h, 16'h0200);
      wreg(8'h2F, 8'h80);
      #1 chk(16'({pa_oe, pb_oe, 2'(tmode)}), 16'(TCP_MODE_NORMAL));
      give_verdict();
   end
endmodule // tcp_top_tb_top
`default_nettype wire
